// File: crg_cmd_check.sv
/*
  Combinational check of one serial boot command against the level.
  Assumes operands are stable for the cycle in which the result is taken.
*/
`include "crg_consts.svh"

module crg_cmd_check
  import crg_pkg::*;
#(
  parameter logic [31:0] LAST_SECTOR = `CRG_LAST_SECTOR,
  parameter logic [31:0] LAST_PAGE = `CRG_LAST_PAGE
) (
  input crg_level_t level,
  input crg_cmd_t cmd,
  input wire logic application_flash_calls,
  input wire logic [31:0] arg0,
  input wire logic [31:0] arg1,
  output logic allowed,
  output logic [7:0] code
);

  logic all_sectors;
  logic all_pages;

  // ----------------------------------------
  // Decision
  // ----------------------------------------
  always_comb begin
    all_sectors = (arg0 == 32'h0000_0000) && (arg1 >= LAST_SECTOR);
    all_pages = (arg0 == 32'h0000_0000) && (arg1 >= LAST_PAGE);
    allowed = 1'b1;
    if (!application_flash_calls) begin
      case (level)
        LVL_PARTIAL: begin
          case (cmd)
            CMD_WR_RAM: allowed = (arg0 >= `CRG_RAM_WR_BOUND);
            CMD_COPY: allowed = (arg0 >= `CRG_SECTOR_BYTES);
            CMD_ERASE: allowed = (arg0 != 32'h0000_0000) || all_sectors;
            CMD_ERASE_PAGE: allowed = (arg0 >= `CRG_PAGES_PER_SECTOR) || all_pages;
            CMD_RD_MEM, CMD_COMPARE, CMD_GO: allowed = 1'b0;
            default: allowed = 1'b1;
          endcase
        end
        LVL_MASS_ERASE: begin
          case (cmd)
            CMD_RD_MEM, CMD_WR_RAM, CMD_GO, CMD_COPY, CMD_COMPARE: allowed = 1'b0;
            CMD_ERASE: allowed = all_sectors;
            CMD_ERASE_PAGE: allowed = all_pages;
            default: allowed = 1'b1;
          endcase
        end
        default: allowed = 1'b1;
      endcase
    end
    code = allowed ? `CRG_RC_SUCCESS : `CRG_RC_PROTECTED;
  end

endmodule : crg_cmd_check

// File: crg_consts.svh
/*
  Constants of the flash code read guard: protection word location and
  patterns, address bounds, register offsets and return codes.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef CRG_CONSTS_SVH
`define CRG_CONSTS_SVH

// ----------------------------------------
// Flash image
// ----------------------------------------
`define CRG_GUARD_OFFSET 32'h0000_02FC
`define CRG_PAT_PIN_OFF 32'h4E69_7370
`define CRG_PAT_PARTIAL 32'h1234_5678
`define CRG_PAT_MASS_ERASE 32'h8765_4321
`define CRG_PAT_LOCKOUT 32'h4321_8765
`define CRG_VEC_WORDS 4'h8

// ----------------------------------------
// Address bounds
// ----------------------------------------
`define CRG_RAM_WR_BOUND 32'h1000_0380
`define CRG_SECTOR_BYTES 32'h0000_0400
`define CRG_LAST_SECTOR 32'h0000_000F
`define CRG_PAGES_PER_SECTOR 32'h0000_0010
`define CRG_LAST_PAGE 32'h0000_00FF
`define CRG_STACK_TOP 32'h1000_03A8
`define CRG_STACK_BYTES 32'h0000_0280
`define CRG_WORK_BYTES 32'h0000_0004
`define CRG_RAM_END 32'h1000_0800

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CRG_REG_STATUS 8'h00
`define CRG_REG_CMD 8'h04
`define CRG_REG_ARG0 8'h08
`define CRG_REG_ARG1 8'h0C
`define CRG_REG_RESULT 8'h10
`define CRG_REG_MON 8'h14

// ----------------------------------------
// Return codes and bus responses
// ----------------------------------------
`define CRG_RC_SUCCESS 8'h00
`define CRG_RC_PROTECTED 8'h01
`define CRG_RESP_OKAY 2'h0
`define CRG_RESP_SLVERR 2'h2

`endif

// File: crg_flash_model.sv
/*
  Flash read port model: vector words 0..7 and the guard word.
  Assumes requests are levels held until the cycle after the answer.
*/
`include "crg_consts.svh"

module crg_flash_model (
  input wire logic aclk,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic [31:0] data,
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:9];
  logic served = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [1:0] wait_n = 2'h0;
  initial begin
    data = 32'h0000_0000;
    valid = 1'b0;
  end
  always @(posedge aclk) begin
    if (req && !served && wait_n == lat) begin
      valid <= 1'b1;
      data <= mem[(addr == `CRG_GUARD_OFFSET) ? 4'h8 : {1'b0, addr[4:2]}];
      served <= 1'b1;
      lat <= lat + 2'h1;
    end else begin
      valid <= 1'b0;
      // Stale data never looks valid
      data <= ~data;
      served <= served && req;
      wait_n <= (req && !served) ? wait_n + 2'h1 : 2'h0;
    end
  end
endmodule : crg_flash_model

// File: crg_pkg.sv
/*
  Types of the flash code read guard: levels, commands, scan states,
  state records and the level decoding functions.
  Assumes crg_consts.svh is on the include path.
*/
`include "crg_consts.svh"

package crg_pkg;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    LVL_NONE = 3'b000,
    LVL_PIN_OFF = 3'b001,
    LVL_PARTIAL = 3'b010,
    LVL_MASS_ERASE = 3'b011,
    LVL_LOCKOUT = 3'b100
  } crg_level_t;

  typedef enum logic [3:0] {
    CMD_UNLOCK = 4'b0000,
    CMD_BAUD = 4'b0001,
    CMD_ECHO = 4'b0010,
    CMD_WR_RAM = 4'b0011,
    CMD_RD_MEM = 4'b0100,
    CMD_PREPARE = 4'b0101,
    CMD_COPY = 4'b0110,
    CMD_GO = 4'b0111,
    CMD_ERASE = 4'b1000,
    CMD_ERASE_PAGE = 4'b1001,
    CMD_BLANK = 4'b1010,
    CMD_PART_ID = 4'b1011,
    CMD_BOOT_VER = 4'b1100,
    CMD_COMPARE = 4'b1101,
    CMD_UID = 4'b1110,
    CMD_CRC = 4'b1111
  } crg_cmd_t;

  typedef enum logic [1:0] {
    SC_REQ = 2'b00,
    SC_WAIT = 2'b01,
    SC_DONE = 2'b10
  } crg_scan_t;

  // ----------------------------------------
  // State records
  // ----------------------------------------
  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic level;
  } crg_sync_state_t;

  typedef struct packed {
    crg_scan_t scan;
    logic [3:0] idx;
    logic [31:0] sum;
    logic nonzero;
    crg_level_t level;
    logic code_valid;
    logic scan_done;
    logic rd_req;
    logic [31:0] rd_addr;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    crg_cmd_t cmd;
    logic application_flash_calls;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic chk_pend;
    logic res_done;
    logic res_allowed;
    logic [7:0] res_code;
    logic stk_ovf;
    logic work_viol;
    logic dbg_en;
    logic pin_en;
    logic isp_enter;
    logic flash_block;
  } crg_state_t;

  // ----------------------------------------
  // Level decoding
  // ----------------------------------------
  function automatic crg_level_t crg_decode(input logic [31:0] word);
    crg_level_t lvl;
    lvl = LVL_NONE;
    case (word)
      `CRG_PAT_PIN_OFF: lvl = LVL_PIN_OFF;
      `CRG_PAT_PARTIAL: lvl = LVL_PARTIAL;
      `CRG_PAT_MASS_ERASE: lvl = LVL_MASS_ERASE;
      `CRG_PAT_LOCKOUT: lvl = LVL_LOCKOUT;
      default: lvl = LVL_NONE;
    endcase
    return lvl;
  endfunction : crg_decode

  function automatic logic crg_debug_ok(input crg_level_t lvl);
    return (lvl == LVL_NONE) || (lvl == LVL_PIN_OFF);
  endfunction : crg_debug_ok

  function automatic logic crg_pin_ok(input crg_level_t lvl, input logic code_valid);
    return !((lvl == LVL_PIN_OFF) || ((lvl == LVL_LOCKOUT) && code_valid));
  endfunction : crg_pin_ok

endpackage : crg_pkg

// File: crg_sync.sv
/*
  Three-stage synchroniser for one pin input with agreement filter.
  Assumes the input is asynchronous to aclk.
*/
`include "crg_consts.svh"

module crg_sync
  import crg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);

  crg_sync_state_t s;
  crg_sync_state_t next_s;

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  // First stage is read only by the second
  always_comb begin
    next_s = s;
    next_s.f1 = pin;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    if (s.f2 == s.f3) begin
      next_s.level = s.f3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : crg_sync

// File: crg_top.sv
/*
  Flash code read guard: power-up scan of the protection word and the
  vector table, level policy outputs, command checking over AXI4-Lite,
  stack and work-RAM monitors, and the fetch block during programming.
  Assumes a same-clock flash read port that answers each request with a
  one-cycle flash_rd_valid, and that aresetn is asserted only at power-up.
*/
`include "crg_consts.svh"

module crg_top
  import crg_pkg::*;
#(
  parameter logic [31:0] RAM_END = `CRG_RAM_END,
  parameter logic [31:0] LAST_SECTOR = `CRG_LAST_SECTOR
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_rd_req,
  output logic [31:0] flash_rd_addr,
  input wire logic [31:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic flash_busy,
  input wire logic entry_pin_n,
  input wire logic [31:0] isp_sp,
  input wire logic isp_sp_valid,
  input wire logic [31:0] work_wr_addr,
  input wire logic work_wr_valid,
  output logic debug_enable,
  output logic entry_pin_sample_enable,
  output logic enter_serial_boot,
  output logic flash_access_block
);

  crg_state_t s;
  crg_state_t next_s;
  logic pin_level;
  logic chk_allowed;
  logic [7:0] chk_code;
  logic [31:0] rd_word;
  logic rd_hit;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  crg_sync #(
    .RESET_VAL(1'b1)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(entry_pin_n),
    .level(pin_level)
  );

  crg_cmd_check #(
    .LAST_SECTOR(LAST_SECTOR),
    .LAST_PAGE(`CRG_LAST_PAGE)
  ) u_check (
    .level(s.level),
    .cmd(s.cmd),
    .application_flash_calls(s.application_flash_calls),
    .arg0(s.arg0),
    .arg1(s.arg1),
    .allowed(chk_allowed),
    .code(chk_code)
  );

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CRG_REG_STATUS: rd_word = {26'h000_0000, s.dbg_en, s.scan_done, s.code_valid, s.level};
      `CRG_REG_CMD: rd_word = {27'h000_0000, s.application_flash_calls, s.cmd};
      `CRG_REG_ARG0: rd_word = s.arg0;
      `CRG_REG_ARG1: rd_word = s.arg1;
      `CRG_REG_RESULT: rd_word = {16'h0000, s.res_code, 6'h00, s.res_allowed, s.res_done};
      `CRG_REG_MON: rd_word = {30'h0000_0000, s.work_viol, s.stk_ovf};
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    case (s.scan)
      SC_REQ: begin
        next_s.rd_req = 1'b1;
        next_s.rd_addr = (s.idx == `CRG_VEC_WORDS) ? `CRG_GUARD_OFFSET : {26'h000_0000, s.idx, 2'b00};
        next_s.scan = SC_WAIT;
      end
      SC_WAIT: begin
        if (flash_rd_valid) begin
          next_s.rd_req = 1'b0;
          if (s.idx == `CRG_VEC_WORDS) begin
            next_s.level = crg_decode(flash_rd_data);
            next_s.code_valid = (s.sum == 32'h0000_0000) && s.nonzero;
            next_s.scan_done = 1'b1;
            next_s.scan = SC_DONE;
          end else begin
            next_s.sum = s.sum + flash_rd_data;
            next_s.nonzero = s.nonzero | (flash_rd_data != 32'h0000_0000);
            next_s.idx = s.idx + 4'h1;
            next_s.scan = SC_REQ;
          end
        end
      end
      SC_DONE: next_s.scan = SC_DONE;
      default: next_s.scan = SC_DONE;
    endcase

    // Policy stays closed until the scan ends
    // Debug kept only at LVL_NONE and LVL_PIN_OFF
    next_s.dbg_en = next_s.scan_done && crg_debug_ok(next_s.level);
    next_s.pin_en = next_s.scan_done && crg_pin_ok(next_s.level, next_s.code_valid);
    next_s.isp_enter = next_s.scan_done && (!next_s.code_valid || (next_s.pin_en && !pin_level));
    next_s.flash_block = flash_busy;

    // Check result one cycle after a command write
    if (s.chk_pend) begin
      next_s.chk_pend = 1'b0;
      next_s.res_done = 1'b1;
      next_s.res_allowed = chk_allowed;
      next_s.res_code = chk_code;
    end

    // Write channel
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_hold && s.w_hold && !s.bvalid) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `CRG_RESP_OKAY;
      case (s.awaddr)
        `CRG_REG_CMD: begin
          if (s.wstrb[0]) begin
            next_s.cmd = crg_cmd_t'(s.wdata[3:0]);
            next_s.application_flash_calls = s.wdata[4];
            next_s.chk_pend = 1'b1;
            next_s.res_done = 1'b0;
          end
        end
        `CRG_REG_ARG0: next_s.arg0 = apply_strb(s.arg0, s.wdata, s.wstrb);
        `CRG_REG_ARG1: next_s.arg1 = apply_strb(s.arg1, s.wdata, s.wstrb);
        `CRG_REG_MON: begin
          if (s.wstrb[0]) begin
            next_s.stk_ovf = s.stk_ovf & ~s.wdata[0];
            next_s.work_viol = s.work_viol & ~s.wdata[1];
          end
        end
        `CRG_REG_STATUS, `CRG_REG_RESULT: next_s.bresp = `CRG_RESP_OKAY;
        default: next_s.bresp = `CRG_RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_hold;
    next_s.wready = !next_s.w_hold;

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_hit ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;

    // Monitors set after the clear, so the set wins
    // Stack window check
    if (isp_sp_valid && ((isp_sp > `CRG_STACK_TOP) || (isp_sp < (`CRG_STACK_TOP - `CRG_STACK_BYTES)))) begin
      next_s.stk_ovf = 1'b1;
    end
    if (work_wr_valid && ((work_wr_addr < (RAM_END - `CRG_WORK_BYTES)) || (work_wr_addr >= RAM_END))) begin
      next_s.work_viol = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign flash_rd_req = s.rd_req;
  assign flash_rd_addr = s.rd_addr;
  assign debug_enable = s.dbg_en;
  assign entry_pin_sample_enable = s.pin_en;
  assign enter_serial_boot = s.isp_enter;
  assign flash_access_block = s.flash_block;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_check_ext;
    s.chk_pend && !s.application_flash_calls;
  endsequence

  sequence seq_result;
    ##1 s.res_done && !s.chk_pend;
  endsequence

  AST_LEVEL_FROZEN: assert property (s.scan_done |=> s.scan_done && $stable(s.level) && $stable(s.code_valid))
    else $error("level changed after power-up scan");
  AST_DEBUG_POLICY: assert property (s.scan_done |-> debug_enable == ((s.level == LVL_NONE) || (s.level == LVL_PIN_OFF)))
    else $error("debug enable disagrees with level");
  AST_PIN_OFF: assert property (s.scan_done && s.level == LVL_PIN_OFF |-> !entry_pin_sample_enable)
    else $error("entry pin sampled in pin-off mode");
  AST_LOCKOUT_PIN: assert property (s.scan_done && s.level == LVL_LOCKOUT && s.code_valid |-> !enter_serial_boot)
    else $error("lockout entered serial boot with valid code");
  AST_IAP_FREE: assert property (s.chk_pend && s.application_flash_calls |=> s.res_allowed && s.res_code == `CRG_RC_SUCCESS)
    else $error("application call was restricted");
  AST_WR_RAM_LOW: assert property (seq_check_ext and (s.level == LVL_PARTIAL && s.cmd == CMD_WR_RAM
    && s.arg0 < `CRG_RAM_WR_BOUND) |-> seq_result ##0 !s.res_allowed && s.res_code == `CRG_RC_PROTECTED)
    else $error("low RAM write not refused");
  AST_COPY_SECTOR0: assert property (seq_check_ext and (s.level == LVL_PARTIAL && s.cmd == CMD_COPY
    && s.arg0 < `CRG_SECTOR_BYTES) |-> seq_result ##0 !s.res_allowed)
    else $error("copy into sector 0 not refused");
  AST_READ_OFF: assert property (seq_check_ext and (s.level == LVL_PARTIAL
    && (s.cmd == CMD_RD_MEM || s.cmd == CMD_COMPARE)) |-> seq_result ##0 !s.res_allowed)
    else $error("read or compare allowed under partial update");
  AST_MASS_PARTIAL_ERASE: assert property (seq_check_ext and (s.level == LVL_MASS_ERASE
    && s.cmd == CMD_ERASE && s.arg1 < LAST_SECTOR) |-> seq_result ##0 s.res_code == `CRG_RC_PROTECTED)
    else $error("partial erase allowed under mass-erase-only");
  AST_FETCH_BLOCK: assert property (flash_busy |=> flash_access_block ##1 (flash_access_block || !$past(flash_busy)))
    else $error("flash not blocked during programming");
  AST_STACK_STICKY: assert property (isp_sp_valid && isp_sp > `CRG_STACK_TOP |=> s.stk_ovf [*2])
    else $error("stack excursion not held");
  AST_STACK_LOW: assert property (isp_sp_valid && (isp_sp < (`CRG_STACK_TOP - `CRG_STACK_BYTES)) |=> s.stk_ovf)
    else $error("stack below its window not flagged");
  AST_WORK_LOW: assert property (work_wr_valid && (work_wr_addr < (RAM_END - `CRG_WORK_BYTES)) |=> s.work_viol)
    else $error("work RAM write below the top word not flagged");
  AST_GUARD_ADDR: assert property (s.scan == SC_WAIT && s.idx == `CRG_VEC_WORDS |-> flash_rd_addr == `CRG_GUARD_OFFSET)
    else $error("guard word read from the wrong address");
  AST_PIN_HONOURED: assert property (s.scan_done && entry_pin_sample_enable && !pin_level |=> enter_serial_boot)
    else $error("sampled entry pin ignored");
  AST_INVALID_BOOTS: assert property (s.scan_done && !s.code_valid |=> enter_serial_boot)
    else $error("invalid user code did not force serial boot");
  AST_SCAN_CLOSED: assert property (!s.scan_done |-> !debug_enable && !entry_pin_sample_enable && !enter_serial_boot)
    else $error("policy opened before the scan ended");
  AST_DEBUG_OFF: assert property (s.scan_done && (s.level == LVL_PARTIAL || s.level == LVL_MASS_ERASE
    || s.level == LVL_LOCKOUT) |-> !debug_enable)
    else $error("debug left open under protection");
  AST_PARTIAL_ERASE0: assert property (seq_check_ext and (s.level == LVL_PARTIAL
    && s.cmd == CMD_ERASE && s.arg0 == 32'h0000_0000 && s.arg1 < LAST_SECTOR) |-> seq_result ##0 !s.res_allowed)
    else $error("sector 0 erase allowed without all sectors");
  AST_MASS_REFUSED: assert property (seq_check_ext and (s.level == LVL_MASS_ERASE
    && (s.cmd == CMD_RD_MEM || s.cmd == CMD_WR_RAM || s.cmd == CMD_GO || s.cmd == CMD_COPY
    || s.cmd == CMD_COMPARE)) |-> seq_result ##0 !s.res_allowed)
    else $error("refused command allowed under mass-erase-only");
  AST_NONE_FREE: assert property (seq_check_ext and (s.level == LVL_NONE) |-> seq_result ##0 s.res_allowed)
    else $error("command refused without protection");

endmodule : crg_top

// File: tb_flash_code_read_protection.sv
/*
  Self-checking bench: power-up scan per level, command checks, pin, monitors.
  Assumes crg_top and crg_flash_model compiled before it.
*/
`include "crg_consts.svh"

module tb_flash_code_read_protection import crg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, sp = 32'h1000_03A8, wk = 32'h1000_07FC;
  logic busy = 1'b0, pin_n = 1'b1, sp_v = 1'b0, wk_v = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, req, rdv, dbg, smp, esb, blk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, raddr, rdd;
  int fails = 0, tests_run = 0, seed = 36;
  logic [31:0] a0t [0:8] = '{0, 0, 1, 0, 16, 32'h0000_03FC, 32'h0000_0400, 32'h1000_037C, 32'h1000_0380};
  logic [31:0] a1t [0:8] = '{15, 14, 15, 255, 255, 255, 255, 255, 255};

  always #4 aclk = ~aclk;

  crg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_rd_req(req),
    .flash_rd_addr(raddr), .flash_rd_data(rdd), .flash_rd_valid(rdv), .flash_busy(busy),
    .entry_pin_n(pin_n), .isp_sp(sp), .isp_sp_valid(sp_v), .work_wr_addr(wk), .work_wr_valid(wk_v),
    .debug_enable(dbg), .entry_pin_sample_enable(smp), .enter_serial_boot(esb),
    .flash_access_block(blk));

  crg_flash_model fm (.aclk(aclk), .req(req), .addr(raddr), .data(rdd), .valid(rdv));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axr

  function automatic logic [7:0] exp_rc(crg_level_t l, logic [3:0] c, logic application_flash_calls, logic [31:0] a0, a1);
    logic ok;
    ok = 1'b1;
    if (!application_flash_calls && l == LVL_PARTIAL) begin
      if (c == CMD_RD_MEM || c == CMD_COMPARE || c == CMD_GO) ok = 1'b0;
      if (c == CMD_WR_RAM && a0 < `CRG_RAM_WR_BOUND) ok = 1'b0;
      if (c == CMD_COPY && a0 < `CRG_SECTOR_BYTES) ok = 1'b0;
      if (c == CMD_ERASE && a0 == 0 && a1 < `CRG_LAST_SECTOR) ok = 1'b0;
      if (c == CMD_ERASE_PAGE && a0 < 16 && !(a0 == 0 && a1 >= `CRG_LAST_PAGE)) ok = 1'b0;
    end
    if (!application_flash_calls && l == LVL_MASS_ERASE) begin
      if (c inside {CMD_RD_MEM, CMD_WR_RAM, CMD_GO, CMD_COPY, CMD_COMPARE}) ok = 1'b0;
      if (c == CMD_ERASE && !(a0 == 0 && a1 >= `CRG_LAST_SECTOR)) ok = 1'b0;
      if (c == CMD_ERASE_PAGE && !(a0 == 0 && a1 >= `CRG_LAST_PAGE)) ok = 1'b0;
    end
    return ok ? `CRG_RC_SUCCESS : `CRG_RC_PROTECTED;
  endfunction : exp_rc

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] pats [0:5];
    crg_level_t lvls [0:5];
    logic [31:0] rd, sum;
    logic [7:0] e;
    logic [1:0] rs;
    crg_level_t lv;
    logic ok, dbg_e, smp_e;
    int r, i, k;
    pats = '{`CRG_PAT_PIN_OFF, `CRG_PAT_PARTIAL, `CRG_PAT_MASS_ERASE, `CRG_PAT_LOCKOUT, 32'h0, 32'h0};
    lvls = '{LVL_PIN_OFF, LVL_PARTIAL, LVL_MASS_ERASE, LVL_LOCKOUT, LVL_NONE, LVL_NONE};
    pats[5] = $random(seed);
    for (r = 0; r < 7; r++) begin
      lv = (r == 6) ? LVL_LOCKOUT : lvls[r];
      ok = (r != 6);
      sum = 32'h0000_0000;
      for (i = 0; i < 7; i++) begin
        fm.mem[i] = ok ? $random(seed) : 32'h0000_0000;
        sum = sum + fm.mem[i];
      end
      fm.mem[7] = 32'h0000_0000 - sum;
      fm.mem[8] = (r == 6) ? `CRG_PAT_LOCKOUT : pats[r];
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      chk({28'h0, dbg, smp, esb, blk}, 32'h0000_0000);
      aresetn <= 1'b1;
      rd = 32'h0000_0000;
      while (rd[4] !== 1'b1) axr(`CRG_REG_STATUS, rd, rs);
      fm.mem[8] = 32'h0000_0000;
      dbg_e = (lv == LVL_NONE) || (lv == LVL_PIN_OFF);
      smp_e = !((lv == LVL_PIN_OFF) || (lv == LVL_LOCKOUT && ok));
      chk({26'h0, rd[5:0]}, {26'h0, dbg_e, 1'b1, ok, lv});
      chk({30'h0, dbg, smp}, {30'h0, dbg_e, smp_e});
      pin_n <= 1'b0;
      repeat (8) @(posedge aclk);
      chk({31'h0, esb}, {31'h0, smp_e || !ok});
      pin_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk({31'h0, esb}, {31'h0, !ok});
      for (i = 0; i < 32; i++) begin
        k = $unsigned($random(seed)) % 9;
        axw(`CRG_REG_ARG0, a0t[k], rs);
        axw(`CRG_REG_ARG1, a1t[k], rs);
        axw(`CRG_REG_CMD, {27'h0, i[4:0]}, rs);
        axr(`CRG_REG_RESULT, rd, rs);
        e = exp_rc(lv, i[3:0], i[4], a0t[k], a1t[k]);
        chk({16'h0, rd[15:0]}, {16'h0, e, 6'h0, e == `CRG_RC_SUCCESS, 1'b1});
      end
      for (i = 0; i < 3; i++) begin
        sp <= (i == 2) ? 32'h1000_03AC : i[0] ? 32'h1000_0124 : 32'h1000_0128;
        wk <= (i == 2) ? 32'h1000_0800 : i[0] ? 32'h1000_07F8 : 32'h1000_07FC;
        sp_v <= 1'b1;
        wk_v <= 1'b1;
        @(posedge aclk);
        sp_v <= 1'b0;
        wk_v <= 1'b0;
        axr(`CRG_REG_MON, rd, rs);
        chk({30'h0, rd[1:0]}, {30'h0, i != 0, i != 0});
        axw(`CRG_REG_MON, 32'h0000_0003, rs);
        axr(`CRG_REG_MON, rd, rs);
        chk({30'h0, rd[1:0]}, 32'h0000_0000);
      end
      axw(8'h40, 32'hFFFF_FFFF, rs);
      chk({30'h0, rs}, {30'h0, `CRG_RESP_SLVERR});
      axr(8'h40, rd, rs);
      chk({rs, rd[29:0]}, {`CRG_RESP_SLVERR, 30'h0});
      axw(`CRG_REG_STATUS, 32'h0000_0000, rs);
      axr(`CRG_REG_STATUS, rd, rs);
      chk({26'h0, rd[5:0]}, {26'h0, dbg_e, 1'b1, ok, lv});
      busy <= 1'b1;
      @(posedge aclk);
      chk({31'h0, blk}, 32'h0000_0000);
      @(posedge aclk);
      chk({31'h0, blk}, 32'h0000_0001);
      busy <= 1'b0;
      @(posedge aclk);
      @(posedge aclk);
      chk({31'h0, blk}, 32'h0000_0000);
      $display("run %0d level %0d done", r, lv);
    end
    close_out();
  end

  initial begin
    #(400_000);
    fails++;
    close_out();
  end
endmodule : tb_flash_code_read_protection
